// File: logic/i2c_master_status_flags.sv
module i2c_master_status_flags (
  input wire logic clk,
  input wire logic rst_b,
  input wire i2c_flags_pkg::reg_acc_t acc,
  input wire i2c_flags_pkg::unit_acc_t unit,
  input wire i2c_flags_pkg::bus_ev_t ev,
  input wire logic enable,
  input wire logic enable_wr,
  input wire logic soft_reset_wr,
  output logic [31:0] rdata,
  output logic acc_err,
  output logic scl_hold,
  output logic [1:0] bus_state_field,
  output logic [2:0] interrupt_flags
);

  // ==========================================================
  // State
  typedef struct packed {
    i2c_flags_pkg::bus_state_t bstate; // Bus state
    logic master_on_bus_flag; // Master flag
    logic read_byte_flag; // Read byte flag
    logic error_flag; // Summary error flag
    logic hold; // SCL held low
    logic length_error_flag;
    logic target_stretch_timeout;
    logic controller_stretch_timeout;
    logic scl_low_timeout_flag;
    logic received_nack_flag;
    logic arbitration_lost_flag;
    logic bus_error_flag;
    logic force_pend; // Force to idle waiting on sync
    logic [31:0] rdata; // Read answer
    logic acc_err; // Rejected access pulse
  } flags_state_t;

  flags_state_t s_q; // Registered state
  flags_state_t s_d; // Next state

  logic [2:0] sync_start; // Start per busy bit
  logic [2:0] sync_busy; // Busy per bit
  logic [2:0] sync_done; // Done per bit

  // ==========================================================
  // Access decode
  logic en_busy; // Enable sync running
  logic wr_ok; // Software write accepted
  logic st_wr; // Status write
  logic if_wr; // Interrupt flag write
  logic addr_wr; // Accepted address write
  logic rel; // Releasing access
  logic owner; // This master owns the bus
  logic mb_set; // Master flag set event
  logic arb_set; // Arbitration lost event
  logic owner_berr; // Bus error while owner
  logic hold_set; // Start of a stall
  logic len_set; // Length error event
  logic any_err; // Any error event
  logic force_req; // Legal force to idle
  logic [15:0] status_rd; // Status view

  assign en_busy = sync_busy[i2c_flags_pkg::SY_ENABLE];
  assign wr_ok = acc.wr & ~en_busy;
  assign st_wr = wr_ok & (acc.addr == i2c_flags_pkg::STATUS_OFF);
  assign if_wr = wr_ok & (acc.addr == i2c_flags_pkg::IRQ_FLAGS_OFF);
  assign addr_wr = unit.addr_wr & ~en_busy;
  // Accesses that let a stalled transfer go on
  assign rel = ~en_busy & (unit.addr_wr | unit.data_wr |
               (unit.data_rd & unit.smart_mode_enable) | (unit.ctrl_wr & unit.cmd_valid));
  assign owner = (s_q.bstate == i2c_flags_pkg::BS_OWNER);
  assign owner_berr = ev.bus_err & owner;
  assign arb_set = ev.arb_lost | ev.arb_lost_nack | owner_berr;
  assign mb_set = ev.tx_byte_done | ev.arb_lost_nack | ev.start_unknown | arb_set;
  // Master flag stalls only when arbitration is not lost, read byte always stalls
  assign hold_set = (mb_set & ~arb_set & ~s_q.arbitration_lost_flag) | ev.rx_byte_done;
  assign len_set = unit.lenen & ev.ack_valid & ev.ack_nack & ~ev.len_done;
  assign any_err = len_set | ev.sext_tout | ev.mext_tout | ev.low_tout | arb_set
                   | ev.bus_err;
  assign force_req = st_wr & enable
                     & (acc.wdata[i2c_flags_pkg::ST_BSTATE +: 2]
                        == i2c_flags_pkg::FORCE_IDLE_CODE)
                     & (s_q.bstate == i2c_flags_pkg::BS_UNKNOWN);

  // ==========================================================
  // Sync busy bits
  always_comb begin
    sync_start = '0;
    sync_start[i2c_flags_pkg::SY_SYS_OP] = enable & ~en_busy
      & (st_wr | unit.ctrl_wr | unit.addr_wr | unit.data_wr);
    sync_start[i2c_flags_pkg::SY_ENABLE] = enable_wr;
    sync_start[i2c_flags_pkg::SY_SOFT_RST] = soft_reset_wr;
  end

  // One timer per busy bit
  genvar g;
  generate
    for (g = 0; g < i2c_flags_pkg::SYNC_KINDS; g++) begin : g_sync
      sync_busy_timer u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .start(sync_start[g]),
        .busy(sync_busy[g]),
        .done(sync_done[g])
      );
    end
  endgenerate

  // ==========================================================
  // Status register view
  always_comb begin
    status_rd = i2c_flags_pkg::STATUS_RST;
    status_rd[i2c_flags_pkg::ST_LENGTH_ERR] = s_q.length_error_flag;
    status_rd[i2c_flags_pkg::ST_SEXT] = s_q.target_stretch_timeout;
    status_rd[i2c_flags_pkg::ST_MEXT] = s_q.controller_stretch_timeout;
    status_rd[i2c_flags_pkg::ST_CLK_HELD] = s_q.hold;
    status_rd[i2c_flags_pkg::ST_LOWT] = s_q.scl_low_timeout_flag;
    status_rd[i2c_flags_pkg::ST_BSTATE +: 2] = s_q.bstate;
    status_rd[i2c_flags_pkg::ST_RX_NACK] = s_q.received_nack_flag;
    status_rd[i2c_flags_pkg::ST_ARBL] = s_q.arbitration_lost_flag;
    status_rd[i2c_flags_pkg::ST_BUS_ERR] = s_q.bus_error_flag;
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic [15:0] w1c; // Status write-one-clear bits
    logic [15:0] f1c; // Flag write-one-clear bits
    w1c = st_wr ? acc.wdata : 16'h0000;
    f1c = if_wr ? acc.wdata : 16'h0000;
    s_d = s_q;
    s_d.acc_err = acc.wr & en_busy;

    // Master flag, set wins over any clear
    s_d.master_on_bus_flag = (s_q.master_on_bus_flag & ~rel & ~f1c[i2c_flags_pkg::IF_MASTER])
                             | mb_set;
    s_d.read_byte_flag = (s_q.read_byte_flag & ~rel & ~f1c[i2c_flags_pkg::IF_READ_BYTE])
                         | ev.rx_byte_done;
    s_d.error_flag = (s_q.error_flag & ~f1c[i2c_flags_pkg::IF_ERROR]) | any_err;
    // Flag clear alone keeps the stall
    s_d.hold = (s_q.hold & ~rel) | hold_set;

    // Error bits cleared by one or by address write
    s_d.length_error_flag = (s_q.length_error_flag & ~addr_wr
                             & ~w1c[i2c_flags_pkg::ST_LENGTH_ERR]) | len_set;
    s_d.target_stretch_timeout = (s_q.target_stretch_timeout & ~addr_wr
                                  & ~w1c[i2c_flags_pkg::ST_SEXT]) | ev.sext_tout;
    s_d.controller_stretch_timeout = (s_q.controller_stretch_timeout & ~addr_wr
                                      & ~w1c[i2c_flags_pkg::ST_MEXT]) | ev.mext_tout;
    s_d.scl_low_timeout_flag = (s_q.scl_low_timeout_flag & ~addr_wr
                                & ~w1c[i2c_flags_pkg::ST_LOWT]) | ev.low_tout;
    s_d.arbitration_lost_flag = (s_q.arbitration_lost_flag & ~addr_wr
                                 & ~w1c[i2c_flags_pkg::ST_ARBL]) | arb_set;
    s_d.bus_error_flag = (s_q.bus_error_flag & ~addr_wr
                          & ~w1c[i2c_flags_pkg::ST_BUS_ERR]) | ev.bus_err;

    // Last ack slot result, writes ignored
    if (ev.ack_valid) begin
      s_d.received_nack_flag = ev.ack_nack;
    end

    // Pending force to idle
    if (force_req) begin
      s_d.force_pend = 1'b1;
    end else if (sync_done[i2c_flags_pkg::SY_SYS_OP]) begin
      s_d.force_pend = 1'b0;
    end

    // Bus state tracking
    if (!enable || en_busy) begin
      s_d.bstate = i2c_flags_pkg::BS_UNKNOWN;
      s_d.force_pend = 1'b0;
    end else begin
      unique case (s_q.bstate)
        i2c_flags_pkg::BS_UNKNOWN: begin
          // Leave only on stop or completed force
          if (ev.stop_seen || (s_q.force_pend && sync_done[i2c_flags_pkg::SY_SYS_OP])) begin
            s_d.bstate = i2c_flags_pkg::BS_IDLE;
          end
        end
        i2c_flags_pkg::BS_IDLE: begin
          if (ev.own_start) begin
            s_d.bstate = i2c_flags_pkg::BS_OWNER;
          end else if (ev.start_seen) begin
            s_d.bstate = i2c_flags_pkg::BS_BUSY;
          end
        end
        i2c_flags_pkg::BS_OWNER: begin
          if (ev.stop_seen) begin
            s_d.bstate = i2c_flags_pkg::BS_IDLE;
          end else if (arb_set) begin
            s_d.bstate = i2c_flags_pkg::BS_BUSY;
          end
        end
        i2c_flags_pkg::BS_BUSY: begin
          if (ev.stop_seen) begin
            s_d.bstate = i2c_flags_pkg::BS_IDLE;
          end
        end
      endcase
    end

    // Read answer, unmapped reads as zero
    if (acc.rd) begin
      s_d.rdata = 32'h0000_0000;
      if (acc.addr == i2c_flags_pkg::STATUS_OFF) begin
        s_d.rdata[15:0] = status_rd;
      end else if (acc.addr == i2c_flags_pkg::SYNC_BUSY_OFF) begin
        s_d.rdata[2:0] = sync_busy;
      end else if (acc.addr == i2c_flags_pkg::IRQ_FLAGS_OFF) begin
        s_d.rdata[i2c_flags_pkg::IF_ERROR] = s_q.error_flag;
        s_d.rdata[i2c_flags_pkg::IF_READ_BYTE] = s_q.read_byte_flag;
        s_d.rdata[i2c_flags_pkg::IF_MASTER] = s_q.master_on_bus_flag;
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign rdata = s_q.rdata;
  assign acc_err = s_q.acc_err;
  assign scl_hold = s_q.hold;
  assign bus_state_field = s_q.bstate;
  assign interrupt_flags = {s_q.error_flag, s_q.read_byte_flag, s_q.master_on_bus_flag};

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_mb_after_byte;
    ev.tx_byte_done |=> interrupt_flags[0];
  endproperty
  a_mb_after_byte: assert property (p_mb_after_byte) else $error("master flag not set");

  property p_mb_nack_arb;
    (ev.arb_lost_nack || ev.start_unknown) |=> interrupt_flags[0];
  endproperty
  a_mb_nack_arb: assert property (p_mb_nack_arb) else $error("master flag missed");

  sequence s_stalled;
    scl_hold && !hold_set;
  endsequence
  sequence s_released;
    !scl_hold;
  endsequence
  property p_release;
    s_stalled ##0 rel |=> s_released;
  endproperty
  a_release: assert property (p_release) else $error("scl not released");

  property p_stall_kept;
    scl_hold && !rel && !mb_set && if_wr && acc.wdata[0] |=> scl_hold && !interrupt_flags[0];
  endproperty
  a_stall_kept: assert property (p_stall_kept) else $error("stall lost on flag clear");

  property p_length_error_flag;
    len_set |=> s_q.length_error_flag;
  endproperty
  a_length_error_flag: assert property (p_length_error_flag) else $error("length error not set");

  property p_ext_clear;
    addr_wr && !ev.mext_tout && !ev.sext_tout |=> !s_q.controller_stretch_timeout
      && !s_q.target_stretch_timeout;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("timeouts not cleared");

  // Writing one clears the low timeout unless a new one lands
  property p_lowt_clear;
    st_wr && acc.wdata[i2c_flags_pkg::ST_LOWT] && !ev.low_tout |=> !s_q.scl_low_timeout_flag;
  endproperty
  a_lowt_clear: assert property (p_lowt_clear) else $error("low timeout not cleared");

  // Writing zero leaves the arbitration flag alone
  property p_arb_zero_keeps;
    st_wr && !addr_wr && !acc.wdata[i2c_flags_pkg::ST_ARBL] && s_q.arbitration_lost_flag
      |=> s_q.arbitration_lost_flag;
  endproperty
  a_arb_zero_keeps: assert property (p_arb_zero_keeps) else $error("arb flag lost");

  property p_unknown_off;
    !enable |=> bus_state_field == 2'h0;
  endproperty
  a_unknown_off: assert property (p_unknown_off) else $error("state not unknown");

  property p_no_bad_force;
    st_wr && s_q.bstate != i2c_flags_pkg::BS_UNKNOWN |-> ##1 !s_q.force_pend;
  endproperty
  a_no_bad_force: assert property (p_no_bad_force) else $error("illegal force taken");

  property p_received_nack_flag;
    ev.ack_valid |=> s_q.received_nack_flag == $past(ev.ack_nack);
  endproperty
  a_received_nack_flag: assert property (p_received_nack_flag) else $error("nack bit wrong");

  property p_owner_berr;
    owner_berr |=> s_q.arbitration_lost_flag && s_q.bus_error_flag && interrupt_flags[0];
  endproperty
  a_owner_berr: assert property (p_owner_berr) else $error("owner bus error incomplete");

  property p_err_flag;
    any_err |=> interrupt_flags[2];
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag not set");

  property p_system_op_sync_busy;
    sync_start[2] |=> sync_busy[2] [*3] ##1 !sync_busy[2] || $past(sync_start[2]);
  endproperty
  a_system_op_sync_busy: assert property (p_system_op_sync_busy) else $error("sync busy timing wrong");

  property p_reject;
    acc.wr && en_busy |=> acc_err && $stable(s_q.force_pend);
  endproperty
  a_reject: assert property (p_reject) else $error("write not rejected");

endmodule : i2c_master_status_flags

// File: logic/i2c_flags_pkg.sv
package i2c_flags_pkg;

  // ==========================================================
  // Register map
  localparam logic [5:0] IRQ_FLAGS_OFF = 6'h18; // Interrupt flags
  localparam logic [5:0] STATUS_OFF = 6'h1a; // Bus status and errors
  localparam logic [5:0] SYNC_BUSY_OFF = 6'h1c; // Sync busy bits

  // ==========================================================
  // Status field positions
  localparam int ST_LENGTH_ERR = 10;
  localparam int ST_SEXT = 9;
  localparam int ST_MEXT = 8;
  localparam int ST_CLK_HELD = 7;
  localparam int ST_LOWT = 6;
  localparam int ST_BSTATE = 4;
  localparam int ST_RX_NACK = 2;
  localparam int ST_ARBL = 1;
  localparam int ST_BUS_ERR = 0;

  // Interrupt flag positions
  localparam int IF_ERROR = 7;
  localparam int IF_READ_BYTE = 1;
  localparam int IF_MASTER = 0;

  // Sync busy positions
  localparam int SY_SYS_OP = 2;
  localparam int SY_ENABLE = 1;
  localparam int SY_SOFT_RST = 0;
  localparam int SYNC_KINDS = 3;

  // ==========================================================
  // Reset values and timing
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [31:0] SYNC_BUSY_RST = 32'h0000_0000;
  localparam logic [3:0] SYNC_CYCLES = 4'h3; // Cycles of one sync

  // ==========================================================
  // Bus state, encoded as the two-bit field
  typedef enum logic [1:0] {
    BS_UNKNOWN,
    BS_IDLE,
    BS_OWNER,
    BS_BUSY
  } bus_state_t;

  localparam logic [1:0] FORCE_IDLE_CODE = 2'h1; // Only legal forced value

  // ==========================================================
  // Software register access
  typedef struct packed {
    logic wr; // Write strobe
    logic rd; // Read strobe
    logic [5:0] addr; // Byte offset
    logic [15:0] wdata; // Write data
  } reg_acc_t;

  // Accesses of the rest of the unit
  typedef struct packed {
    logic addr_wr; // Address field written
    logic data_wr; // Data written
    logic data_rd; // Data read
    logic ctrl_wr; // Control register written
    logic cmd_valid; // Control write holds a valid command
    logic smart_mode_enable; // Smart mode on
    logic lenen; // Automatic length on
  } unit_acc_t;

  // Bus engine events, one-cycle pulses
  typedef struct packed {
    logic tx_byte_done; // Byte sent in write mode
    logic rx_byte_done; // Byte received cleanly in read mode
    logic arb_lost; // Lost on high bit or start
    logic arb_lost_nack; // Lost while sending NACK
    logic start_unknown; // Start tried in unknown state
    logic ack_valid; // Ack slot sampled
    logic ack_nack; // Ack slot was NACK
    logic len_done; // Byte count reached
    logic sext_tout; // Target extend timeout
    logic mext_tout; // Controller extend timeout
    logic low_tout; // SCL low timeout
    logic bus_err; // Illegal bus condition
    logic start_seen; // Start by another master
    logic own_start; // Own start won
    logic stop_seen; // Stop seen
  } bus_ev_t;

endpackage : i2c_flags_pkg

// File: logic/sync_busy_timer.sv
// ============================================================
// One synchronisation busy bit with its timer
module sync_busy_timer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [3:0] cnt;
  } timer_state_t;

  timer_state_t s_q; // Registered state
  timer_state_t s_d; // Next state

  // Count down the sync time, a new start restarts it
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.busy = 1'b1;
      s_d.cnt = i2c_flags_pkg::SYNC_CYCLES;
    end else if (s_q.busy) begin
      s_d.cnt = s_q.cnt - 4'h1;
      if (s_q.cnt == 4'h1) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;

endmodule : sync_busy_timer

// File: tb/bus_event_source.sv
// ==========================================================
// Far side of the bus: targets and rival masters as events
module bus_event_source (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire i2c_flags_pkg::bus_ev_t req,
  output i2c_flags_pkg::bus_ev_t ev
);
  timeunit 1ns;
  timeprecision 1ps;

  // One-cycle event pulse per request, quiet otherwise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ev <= '0;
    end else begin
      ev <= go ? req : '0;
    end
  end
endmodule : bus_event_source

// File: tb/tb_i2c_master_status_flags.sv
// ==========================================================
// Bench for the master status and flag logic
module tb_i2c_master_status_flags;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  i2c_flags_pkg::reg_acc_t acc = '0; // Software access
  i2c_flags_pkg::unit_acc_t unit = '0; // Rest of the unit
  i2c_flags_pkg::bus_ev_t ev; // Events from far side
  i2c_flags_pkg::bus_ev_t ev_req = '0; // Event to send
  logic ev_go = 1'b0;
  logic enable = 1'b0;
  logic enable_wr = 1'b0;
  logic soft_reset_wr = 1'b0;
  logic [31:0] rdata;
  logic acc_err;
  logic scl_hold;
  logic [1:0] bus_state_field;
  logic [2:0] interrupt_flags;
  logic err_seen; // Refusal pulse seen in last write
  logic [31:0] v; // Last read answer
  int n_mismatch = 0;
  int checked = 0;

  // ==========================================================
  // Clock, design and far side
  always #12.5 clk = ~clk;

  i2c_master_status_flags dut (
    .clk(clk), .rst_b(rst_b), .acc(acc), .unit(unit), .ev(ev), .enable(enable),
    .enable_wr(enable_wr), .soft_reset_wr(soft_reset_wr), .rdata(rdata),
    .acc_err(acc_err), .scl_hold(scl_hold), .bus_state_field(bus_state_field),
    .interrupt_flags(interrupt_flags)
  );

  bus_event_source far (.clk(clk), .rst_b(rst_b), .go(ev_go), .req(ev_req), .ev(ev));

  // ==========================================================
  // Shared tasks
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Register write, effect visible on return
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    acc = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick();
    acc = '0;
    err_seen = acc_err;
    tick();
  endtask : wr

  // Register read of one bit against expectation
  task automatic rbit(input logic [5:0] a, input int b, input logic e, input string what);
    acc = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    tick();
    acc = '0;
    v = rdata;
    check(what, {31'h0, v[b]}, {31'h0, e});
  endtask : rbit

  // Far-side event, flags settled on return
  task automatic fire(input i2c_flags_pkg::bus_ev_t e);
    ev_req = e;
    ev_go = 1'b1;
    tick();
    ev_go = 1'b0;
    tick(2);
  endtask : fire

  // One-cycle access from the rest of the unit
  task automatic upulse(input i2c_flags_pkg::unit_acc_t u);
    unit = u;
    tick();
    unit = '0;
    tick(2);
  endtask : upulse

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check("state", {30'h0, bus_state_field}, 32'h0);
    rbit(6'h1a, 5, 1'b0, "status");
    check("status", v, 32'h0);
    rbit(6'h1c, 0, 1'b0, "sync");
    check("sync", v, 32'h0);
    rbit(6'h3e, 0, 1'b0, "unmapped");
    check("unmapped", v, 32'h0);
    soft_reset_wr = 1'b1;
    tick();
    soft_reset_wr = 1'b0;
    rbit(6'h1c, 0, 1'b1, "soft_reset_sync_busy busy");
    tick(5);
    $display("test reset done");
  endtask : t_reset

  task automatic t_enable();
    i2c_flags_pkg::bus_ev_t e;
    enable = 1'b1;
    enable_wr = 1'b1;
    tick();
    enable_wr = 1'b0;
    rbit(6'h1c, 1, 1'b1, "enable busy");
    wr(6'h18, 16'h0000);
    check("refused", {31'h0, err_seen}, 32'h1);
    tick(4);
    check("state", {30'h0, bus_state_field}, 32'h0);
    e = '0;
    e.start_unknown = 1'b1;
    fire(e);
    check("mb", {31'h0, interrupt_flags[0]}, 32'h1);
    upulse('{addr_wr: 1'b1, default: 1'b0});
    wr(6'h1a, 16'h0020);
    tick(5);
    check("state", {30'h0, bus_state_field}, 32'h0);
    wr(6'h1a, 16'h0010);
    rbit(6'h1c, 2, 1'b1, "system_op_sync_busy");
    tick(4);
    check("state", {30'h0, bus_state_field}, 32'h1);
    $display("test enable done");
  endtask : t_enable

  task automatic t_hold();
    i2c_flags_pkg::bus_ev_t e;
    i2c_flags_pkg::unit_acc_t u;
    for (int i = 0; i < 4; i++) begin
      e = '0;
      e.tx_byte_done = (i != 3);
      e.rx_byte_done = (i == 3);
      fire(e);
      check("hold", {31'h0, scl_hold}, 32'h1);
      check("flags", {29'h0, interrupt_flags}, (i == 3) ? 32'h2 : 32'h1);
      rbit(6'h1a, 7, 1'b1, "clock held");
      u = '0;
      if (i == 0) begin
        wr(6'h18, 16'h0000);
        check("mb", {31'h0, interrupt_flags[0]}, 32'h1);
        wr(6'h18, 16'h0001);
        check("mb", {31'h0, interrupt_flags[0]}, 32'h0);
        upulse('{data_rd: 1'b1, default: 1'b0});
        check("hold", {31'h0, scl_hold}, 32'h1);
        u.addr_wr = 1'b1;
      end else if (i == 1) begin
        u.data_wr = 1'b1;
      end else if (i == 2) begin
        u.data_rd = 1'b1;
        u.smart_mode_enable = 1'b1;
      end else begin
        u.ctrl_wr = 1'b1;
        u.cmd_valid = 1'b1;
      end
      upulse(u);
      check("hold", {31'h0, scl_hold}, 32'h0);
      check("flags", {29'h0, interrupt_flags}, 32'h0);
      rbit(6'h1a, 7, 1'b0, "clock held");
    end
    $display("test hold done");
  endtask : t_hold

  task automatic t_errors();
    i2c_flags_pkg::bus_ev_t e;
    int b;
    for (int i = 0; i < 4; i++) begin
      e = '0;
      e.sext_tout = (i == 0);
      e.mext_tout = (i == 1);
      e.low_tout = (i == 2);
      e.ack_valid = (i == 3);
      e.ack_nack = (i == 3);
      b = (i == 0) ? 9 : (i == 1) ? 8 : (i == 2) ? 6 : 10;
      unit.lenen = (i == 3);
      fire(e);
      unit.lenen = 1'b0;
      rbit(6'h1a, b, 1'b1, "error bit");
      check("error flag", {31'h0, interrupt_flags[2]}, 32'h1);
      wr(6'h1a, 16'h0000);
      rbit(6'h1a, b, 1'b1, "error bit");
      if (i == 3) begin
        rbit(6'h1a, 2, 1'b1, "nack");
        wr(6'h1a, 16'h0004);
        rbit(6'h1a, 2, 1'b1, "nack");
        upulse('{addr_wr: 1'b1, default: 1'b0});
      end else begin
        wr(6'h1a, 16'h0001 << b);
      end
      rbit(6'h1a, b, 1'b0, "error bit");
      wr(6'h18, 16'h0080);
      check("error flag", {31'h0, interrupt_flags[2]}, 32'h0);
    end
    $display("test errors done");
  endtask : t_errors

  task automatic t_arb_bus();
    fire('{arb_lost: 1'b1, default: 1'b0});
    rbit(6'h1a, 1, 1'b1, "arb lost");
    check("mb", {31'h0, interrupt_flags[0]}, 32'h1);
    check("hold", {31'h0, scl_hold}, 32'h0);
    wr(6'h1a, 16'h0000);
    rbit(6'h1a, 1, 1'b1, "arb lost");
    wr(6'h1a, 16'h0002);
    rbit(6'h1a, 1, 1'b0, "arb lost");
    wr(6'h18, 16'h0081);
    fire('{arb_lost_nack: 1'b1, default: 1'b0});
    check("mb", {31'h0, interrupt_flags[0]}, 32'h1);
    rbit(6'h1a, 1, 1'b1, "arb lost");
    wr(6'h1a, 16'h0002);
    wr(6'h18, 16'h0081);
    fire('{bus_err: 1'b1, default: 1'b0});
    rbit(6'h1a, 0, 1'b1, "bus error");
    rbit(6'h1a, 1, 1'b0, "arb lost");
    wr(6'h1a, 16'h0001);
    rbit(6'h1a, 0, 1'b0, "bus error");
    fire('{own_start: 1'b1, default: 1'b0});
    check("state", {30'h0, bus_state_field}, 32'h2);
    fire('{bus_err: 1'b1, default: 1'b0});
    rbit(6'h1a, 1, 1'b1, "arb lost");
    check("mb", {31'h0, interrupt_flags[0]}, 32'h1);
    upulse('{addr_wr: 1'b1, default: 1'b0});
    rbit(6'h1a, 0, 1'b0, "bus error");
    rbit(6'h1a, 1, 1'b0, "arb lost");
    fire('{stop_seen: 1'b1, default: 1'b0});
    fire('{start_seen: 1'b1, default: 1'b0});
    check("state", {30'h0, bus_state_field}, 32'h3);
    enable = 1'b0;
    enable_wr = 1'b1;
    tick();
    enable_wr = 1'b0;
    tick(5);
    check("state", {30'h0, bus_state_field}, 32'h0);
    $display("test arbitration done");
  endtask : t_arb_bus

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    tick(3);
    rst_b = 1'b1;
    tick();
    t_reset();
    t_enable();
    t_hold();
    t_errors();
    t_arb_bus();
    end_of_test();
  end

  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_i2c_master_status_flags
